// *** tb/ssp_mem_model.sv ***
// Memory side model answering stack requests with random latency
`timescale 1ns/1ns
module ssp_mem_model import ssp_pkg::*; (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_mem_valid,
  input wire ssp_mem_s i_mem,
  input wire logic i_fail,
  output logic o_ack,
  output logic o_fault,
  output logic [31:0] o_rdata
);
  logic [1:0] wait_reg;
  // Outside ack, ack stays low while fault and data toggle so a stale sample never matches
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ack <= 1'b0;
      o_fault <= 1'b0;
      o_rdata <= 32'h0;
      wait_reg <= 2'h0;
    end else if (i_mem_valid && !o_ack && wait_reg == 2'h0) begin
      o_ack <= 1'b1;
      o_fault <= i_fail;
      o_rdata <= {~i_mem.addr[15:0], i_mem.addr[15:0] ^ 16'h5A5A};
      wait_reg <= 2'($urandom % 3);
    end else begin
      o_ack <= 1'b0;
      o_fault <= ~o_fault;
      o_rdata <= ~o_rdata;
      if (i_mem_valid && wait_reg != 2'h0) begin
        wait_reg <= wait_reg - 2'h1;
      end
    end
  end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench of the selector and error code stack engine
`timescale 1ns/1ns
module tb_top import ssp_pkg::*;;
  logic i_clk, i_reset_n, cv, mflt;
  ssp_cmd_s cmd;
  ssp_mem_s mq[2][$];
  ssp_resp_s rq[2][$];
  bit pq[2][$];
  int err_total, total_checks, pend;
  // Narrow build in copy 0, full build in copy 1, both fed the same commands
  for (genvar b = 0; b < 2; b++) begin : g_build
    logic rdy, mv, ack, flt, rv, pp;
    logic [31:0] rd, msk;
    ssp_mem_s mem, em, got;
    ssp_resp_s resp, er;
    ssp_stack_ops #(.FULL_WRITE(b == 1)) uut (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .i_cmd_valid(cv), .i_cmd(cmd), .o_cmd_ready(rdy), .o_mem_valid(mv), .o_mem(mem),
      .i_mem_ack(ack), .i_mem_fault(flt), .i_mem_rdata(rd), .o_resp_valid(rv), .o_resp(resp));
    ssp_mem_model mdl (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_mem_valid(mv), .i_mem(mem),
      .i_fail(mflt), .o_ack(ack), .o_fault(flt), .o_rdata(rd));
    always @(posedge i_clk) begin
      if (cv) chk(69'(rdy), 69'(1));
      if (mv && ack) begin
        em = (mq[b].size() != 0) ? mq[b].pop_front() : '1;
        msk = em.wr ? ((em.be == 4'hF) ? 32'hFFFF_FFFF : 32'h0000_FFFF) : 32'h0;
        got = mem;
        got.wdata = got.wdata & msk;
        em.wdata = em.wdata & msk;
        chk(got, em);
      end
      if (rv) begin
        er = (rq[b].size() != 0) ? rq[b].pop_front() : '1;
        pp = (pq[b].size() != 0) ? pq[b].pop_front() : 1'b0;
        chk(69'(resp[66:32]), 69'(er[66:32]));
        if (pp) chk(69'(resp.pop_data), 69'(er.pop_data));
        pend = pend - 1;
      end
    end
  end
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  task automatic chk(input logic [68:0] got, input logic [68:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic run(ssp_op_e op, logic o32, s32, rm, big, logic [31:0] lim, sp, idx,
                     logic [15:0] v, logic mf);
    ssp_cmd_s c;
    ssp_mem_s m;
    ssp_resp_s r;
    logic [31:0] a, ns, rdat;
    int sz, nb;
    logic wr, wrap;
    for (int k = 0; k < 300 && pend != 0; k++) @(posedge i_clk);
    wr = op == SSP_PUSH_SEL || op == SSP_PUSH_ERR;
    sz = (op == SSP_PUSH_ERR) ? (s32 ? 4 : 2) : (o32 ? 4 : 2);
    a = s32 ? sp : {16'h0000, sp[15:0]};
    ns = wr ? a - sz : a + sz;
    if (wr) a = s32 ? ns : {16'h0000, ns[15:0]};
    wrap = op == SSP_POP_MEM && !s32 && a[15:0] == (o32 ? 16'hFFFC : 16'hFFFE);
    rdat = {~a[15:0], a[15:0] ^ 16'h5A5A};
    for (int b = 0; b < 2; b++) begin
      nb = (op == SSP_POP_MEM || b == 1) ? sz : 2;
      r = '0;
      r.stack_pointer = sp;
      if (b == 1 && wrap && (rm || !big)) r.stack_fault = 1'b1;
      else if (a + nb - 1 > lim) r.fault = 1'b1;
      else begin
        m = '{wr, a, {16'h0000, v}, (nb == 4) ? 4'hF : 4'h3};
        mq[b].push_back(m);
        if (mf) r.fault = 1'b1;
        else begin
          // Wrapped write goes to offset zero or 10000h
          m.addr = (wrap ? ((b == 1) ? 32'h0001_0000 : 32'h0) :
                    (s32 ? ns : {16'h0000, ns[15:0]})) + idx;
          m.wr = 1'b1;
          m.wdata = rdat;
          if (op == SSP_POP_MEM) mq[b].push_back(m);
          r.sp_we = 1'b1;
          // Upper half of the pointer is left alone on a 16-bit stack
          r.stack_pointer = s32 ? ns : {sp[31:16], ns[15:0]};
          r.pop_data = {16'h0000, rdat[15:0]};
        end
      end
      rq[b].push_back(r);
      pq[b].push_back(op == SSP_POP_SEL && r.sp_we);
    end
    c = '{op, o32, s32, rm, big, lim, v, idx, sp};
    pend = 2;
    @(posedge i_clk);
    cv <= 1'b1;
    cmd <= c;
    mflt <= mf;
    @(posedge i_clk);
    cv <= 1'b0;
  endtask
  initial begin
    #(4 * 20000);
    err_total++;
    results();
  end
  initial begin
    i_reset_n = 1'b0;
    cv = 1'b0;
    cmd = '0;
    mflt = 1'b0;
    void'($urandom(32'hcba3));
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    for (int k = 0; k < 4; k++) begin
      run(k[1] ? SSP_POP_SEL : SSP_PUSH_SEL, k[0], 1, 0, 1, '1, 32'h1000, 0, 16'h8421, 0);
    end
    // Upper two bytes past the limit
    run(SSP_PUSH_SEL, 1, 1, 0, 1, 32'h0FFF, 32'h1002, 0, 16'h1234, 0);
    run(SSP_POP_SEL, 1, 1, 0, 1, 32'h0FFF, 32'h0FFE, 0, 16'h0, 0);
    run(SSP_PUSH_ERR, 0, 1, 0, 1, '1, 32'h2000, 0, 16'hBEEF, 0);
    run(SSP_PUSH_ERR, 1, 0, 0, 1, '1, 32'h2000, 0, 16'hBEEF, 0);
    for (int k = 0; k < 8; k++) begin
      run(SSP_POP_MEM, k[0], 0, k[1], k[2], '1, k[0] ? 32'hFFFC : 32'hFFFE, 32'h24, 0, 0);
    end
    run(SSP_POP_MEM, 1, 0, 0, 1, '1, 32'h0100, 32'h20, 0, 0);
    run(SSP_PUSH_SEL, 1, 1, 0, 1, '1, 32'h1000, 0, 16'h1, 1);
    run(SSP_POP_MEM, 1, 1, 0, 1, '1, 32'h3000, 32'h8, 0, 1);
    for (int k = 0; k < 60; k++) begin
      run(ssp_op_e'($urandom % 4), 1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom),
          '1, ($urandom % 32'h7000) + 32'h100, $urandom % 256, 16'($urandom),
          ($urandom % 8) == 0);
    end
    for (int k = 0; k < 300 && pend != 0; k++) @(posedge i_clk);
    chk(69'(mq[0].size() + mq[1].size() + rq[0].size() + rq[1].size()), 69'(0));
    results();
  end
endmodule

// *** verilog/ssp_params.svh ***
// Constants of the selector and error code stack operation block
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH
`define SSP_SIZE_WORD 3'd2
`define SSP_SIZE_DWORD 3'd4
`define SSP_BE_WORD 4'h3
`define SSP_BE_DWORD 4'hF
`define SSP_WRAP_BASE 32'h0001_0000
`define SSP_WRAP_SP32 16'hFFFC
`define SSP_WRAP_SP16 16'hFFFE
`define SSP_ZERO_HI 16'h0000
`define SSP_FULL_WRITE_DEF 1'b0
`endif

// *** verilog/ssp_pkg.sv ***
// Types of the selector and error code stack operation block
package ssp_pkg;
  typedef enum logic [1:0] {
    SSP_PUSH_SEL = 2'h0,
    SSP_POP_SEL = 2'h1,
    SSP_PUSH_ERR = 2'h2,
    SSP_POP_MEM = 2'h3
  } ssp_op_e;
  typedef enum logic [2:0] {
    SSP_ST_IDLE = 3'b001,
    SSP_ST_READ = 3'b010,
    SSP_ST_WRITE = 3'b100
  } ssp_state_e;
  typedef struct packed {
    ssp_op_e op;
    logic op32;
    logic stack32;
    logic real_mode;
    logic seg_big;
    logic [31:0] seg_limit;
    logic [15:0] value;
    logic [31:0] index_disp;
    logic [31:0] stack_pointer;
  } ssp_cmd_s;
  typedef struct packed {
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } ssp_mem_s;
  typedef struct packed {
    logic fault;
    logic stack_fault;
    logic sp_we;
    logic [31:0] stack_pointer;
    logic [31:0] pop_data;
  } ssp_resp_s;
endpackage

// *** verilog/ssp_stack_ops.sv ***
// Selector, error code and pop-to-memory stack operation engine
`timescale 1ns/1ns
`include "ssp_params.svh"
module ssp_stack_ops import ssp_pkg::*; #(
  parameter bit FULL_WRITE = `SSP_FULL_WRITE_DEF
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_cmd_valid,
  input wire ssp_cmd_s i_cmd,
  output logic o_cmd_ready,
  output logic o_mem_valid,
  output ssp_mem_s o_mem,
  input wire logic i_mem_ack,
  input wire logic i_mem_fault,
  input wire logic [31:0] i_mem_rdata,
  output logic o_resp_valid,
  output ssp_resp_s o_resp
);
  ssp_state_e state_reg;
  ssp_cmd_s cmd_reg;
  logic [31:0] sp_new_reg;
  logic [2:0] size_reg;
  logic wrap_reg;
  logic start;
  logic is_push;
  logic [2:0] size;
  logic [2:0] nbytes;
  logic [31:0] sp_new;
  logic [31:0] acc_addr;
  logic [32:0] acc_end;
  logic limit_bad;
  logic wrap;
  logic wrap_fault;
  logic done_ack;

  function automatic logic [3:0] be_of(input logic [2:0] n);
    be_of = (n == `SSP_SIZE_DWORD) ? `SSP_BE_DWORD : `SSP_BE_WORD;
  endfunction

  // Pointer step on a 16-bit stack only touches the low half, so it wraps at 64K
  function automatic logic [31:0] step(input logic [31:0] sp, input logic s32,
                                       input logic dn, input logic [2:0] n);
    logic [31:0] r;
    r = dn ? sp - {29'h0, n} : sp + {29'h0, n};
    step = s32 ? r : {sp[31:16], r[15:0]};
  endfunction

  assign start = i_cmd_valid && o_cmd_ready;
  assign is_push = (i_cmd.op == SSP_PUSH_SEL) || (i_cmd.op == SSP_PUSH_ERR);
  assign done_ack = o_mem_valid && i_mem_ack;

  always_comb begin
    if (i_cmd.op == SSP_PUSH_ERR) begin
      size = i_cmd.stack32 ? `SSP_SIZE_DWORD : `SSP_SIZE_WORD;
    end else begin
      size = i_cmd.op32 ? `SSP_SIZE_DWORD : `SSP_SIZE_WORD;
    end
    // Narrow build never touches bytes three and four of a selector or error code
    if (FULL_WRITE || i_cmd.op == SSP_POP_MEM) begin
      nbytes = size;
    end else begin
      nbytes = `SSP_SIZE_WORD;
    end
    sp_new = step(i_cmd.stack_pointer, i_cmd.stack32, is_push, size);
    acc_addr = is_push ? sp_new : i_cmd.stack_pointer;
    if (!i_cmd.stack32) begin
      acc_addr = {16'h0000, acc_addr[15:0]};
    end
    acc_end = {1'b0, acc_addr} + {30'h0, nbytes} - 33'h1;
    limit_bad = acc_end > {1'b0, i_cmd.seg_limit};
    wrap = (i_cmd.op == SSP_POP_MEM) && !i_cmd.stack32 &&
           (i_cmd.stack_pointer[15:0] ==
            ((size == `SSP_SIZE_DWORD) ? `SSP_WRAP_SP32 : `SSP_WRAP_SP16));
    wrap_fault = FULL_WRITE && wrap && (i_cmd.real_mode || !i_cmd.seg_big);
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cmd_reg <= '0;
      sp_new_reg <= 32'h0;
      size_reg <= 3'h0;
      wrap_reg <= 1'b0;
    end else if (start) begin
      cmd_reg <= i_cmd;
      sp_new_reg <= sp_new;
      size_reg <= size;
      wrap_reg <= wrap;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= SSP_ST_IDLE;
      o_cmd_ready <= 1'b0;
    end else begin
      case (state_reg)
        SSP_ST_IDLE: begin
          o_cmd_ready <= 1'b1;
          if (start && !limit_bad && !wrap_fault) begin
            state_reg <= is_push ? SSP_ST_WRITE : SSP_ST_READ;
            o_cmd_ready <= 1'b0;
          end
        end
        SSP_ST_READ: begin
          if (done_ack) begin
            if (!i_mem_fault && cmd_reg.op == SSP_POP_MEM) begin
              state_reg <= SSP_ST_WRITE;
            end else begin
              state_reg <= SSP_ST_IDLE;
              o_cmd_ready <= 1'b1;
            end
          end
        end
        SSP_ST_WRITE: begin
          if (done_ack) begin
            state_reg <= SSP_ST_IDLE;
            o_cmd_ready <= 1'b1;
          end
        end
        default: begin
          state_reg <= SSP_ST_IDLE;
          o_cmd_ready <= 1'b1;
        end
      endcase
    end
  end

  // Request stands until the memory path acknowledges it
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_mem_valid <= 1'b0;
      o_mem <= '0;
    end else if (start && !limit_bad && !wrap_fault) begin
      o_mem_valid <= 1'b1;
      o_mem.wr <= is_push;
      o_mem.addr <= acc_addr;
      o_mem.wdata <= {`SSP_ZERO_HI, i_cmd.value};
      o_mem.be <= be_of(nbytes);
    end else if (done_ack && state_reg == SSP_ST_READ && !i_mem_fault &&
                 cmd_reg.op == SSP_POP_MEM) begin
      o_mem_valid <= 1'b1;
      o_mem.wr <= 1'b1;
      // Base is the pointer after the pop; the wrapped case differs per build
      if (wrap_reg && FULL_WRITE) begin
        o_mem.addr <= `SSP_WRAP_BASE + cmd_reg.index_disp;
      end else begin
        // A 16-bit stack addresses with the low half of the pointer only
        o_mem.addr <= (cmd_reg.stack32 ? sp_new_reg : {16'h0000, sp_new_reg[15:0]}) +
                      cmd_reg.index_disp;
      end
      o_mem.wdata <= (size_reg == `SSP_SIZE_DWORD) ? i_mem_rdata :
                     {`SSP_ZERO_HI, i_mem_rdata[15:0]};
      o_mem.be <= be_of(size_reg);
    end else if (done_ack) begin
      o_mem_valid <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_resp_valid <= 1'b0;
      o_resp <= '0;
    end else if (start && (limit_bad || wrap_fault)) begin
      o_resp_valid <= 1'b1;
      o_resp <= '0;
      o_resp.fault <= limit_bad && !wrap_fault;
      o_resp.stack_fault <= wrap_fault;
      o_resp.stack_pointer <= i_cmd.stack_pointer;
    end else if (done_ack && !(state_reg == SSP_ST_READ && !i_mem_fault &&
                               cmd_reg.op == SSP_POP_MEM)) begin
      o_resp_valid <= 1'b1;
      o_resp.fault <= i_mem_fault;
      o_resp.stack_fault <= 1'b0;
      o_resp.sp_we <= !i_mem_fault;
      // Pointer moves by the operand size even when fewer bytes moved
      o_resp.stack_pointer <= i_mem_fault ? cmd_reg.stack_pointer : sp_new_reg;
      o_resp.pop_data <= (cmd_reg.op == SSP_POP_SEL) ?
                         {`SSP_ZERO_HI, i_mem_rdata[15:0]} : 32'h0;
    end else begin
      o_resp_valid <= 1'b0;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_reject_limit;
    start && limit_bad && !wrap_fault;
  endsequence
  sequence s_fault_out;
    o_resp_valid && o_resp.fault && !o_mem_valid;
  endsequence
  sequence s_wrap_fault_in;
    start && FULL_WRITE && wrap && (i_cmd.real_mode || !i_cmd.seg_big);
  endsequence

  property p_narrow_push;
    o_mem_valid && o_mem.wr && cmd_reg.op == SSP_PUSH_SEL && !FULL_WRITE |->
      o_mem.be == `SSP_BE_WORD;
  endproperty
  a_narrow_push: assert property (p_narrow_push) else $error("narrow push width");

  property p_full_push;
    start && i_cmd.op == SSP_PUSH_SEL && FULL_WRITE && !limit_bad |=>
      o_mem.be == (cmd_reg.op32 ? `SSP_BE_DWORD : `SSP_BE_WORD) && o_mem.wdata[31:16] == 16'h0;
  endproperty
  a_full_push: assert property (p_full_push) else $error("full push width");

  property p_narrow_pop;
    o_mem_valid && !o_mem.wr && cmd_reg.op == SSP_POP_SEL && !FULL_WRITE |->
      o_mem.be == `SSP_BE_WORD;
  endproperty
  a_narrow_pop: assert property (p_narrow_pop) else $error("narrow pop width");

  property p_full_pop_sp;
    state_reg == SSP_ST_READ && cmd_reg.op == SSP_POP_SEL && done_ack && !i_mem_fault |=>
      o_resp_valid && o_resp.sp_we &&
      o_resp.stack_pointer == step(cmd_reg.stack_pointer, cmd_reg.stack32, 1'b0, size_reg);
  endproperty
  a_full_pop_sp: assert property (p_full_pop_sp) else $error("pop pointer step");

  property p_limit_fault;
    s_reject_limit |=> s_fault_out;
  endproperty
  a_limit_fault: assert property (p_limit_fault) else $error("limit fault missing");

  property p_wrap_narrow;
    o_mem_valid && o_mem.wr && cmd_reg.op == SSP_POP_MEM && wrap_reg && !FULL_WRITE |->
      o_mem.addr == cmd_reg.index_disp;
  endproperty
  a_wrap_narrow: assert property (p_wrap_narrow) else $error("wrap address");

  property p_wrap_fault;
    s_wrap_fault_in |=> o_resp_valid && o_resp.stack_fault && !o_mem_valid;
  endproperty
  a_wrap_fault: assert property (p_wrap_fault) else $error("wrap stack fault");

  property p_err_narrow;
    o_resp_valid && o_resp.sp_we && cmd_reg.op == SSP_PUSH_ERR && cmd_reg.stack32 |->
      o_resp.stack_pointer == cmd_reg.stack_pointer - 32'h4;
  endproperty
  a_err_narrow: assert property (p_err_narrow) else $error("error code pointer");

  property p_err_full;
    o_mem_valid && cmd_reg.op == SSP_PUSH_ERR && cmd_reg.stack32 && FULL_WRITE |->
      o_mem.be == `SSP_BE_DWORD && o_mem.wdata[31:16] == 16'h0;
  endproperty
  a_err_full: assert property (p_err_full) else $error("error code width");

  property p_req_hold;
    o_mem_valid && !i_mem_ack |=> o_mem_valid && $stable(o_mem);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped");
endmodule
